/* File: common/psram_port_pkg.sv */
// shared constants and types for the synchronous burst memory port
package psram_port_pkg;

    // ************************************************************
    // data path shape and default configuration
    // ************************************************************
    localparam int DATA_W        = 16;
    localparam int BYTE_W        = 8;
    localparam int BYTES         = DATA_W / BYTE_W;
    localparam int ADDR_W_DEF    = 21;
    localparam int LATENCY_DEF   = 5;
    localparam int BURST_LEN_DEF = 4;

    // ************************************************************
    // control pin positions inside the synchronised control vector
    // ************************************************************
    localparam int CTL_W       = 7;
    localparam int CTL_CLK     = 0;
    localparam int CTL_CS      = 1;
    localparam int CTL_STROBE  = 2;
    localparam int CTL_OE      = 3;
    localparam int CTL_WE      = 4;
    localparam int CTL_LOWER   = 5;
    localparam int CTL_UPPER   = 6;

    // ************************************************************
    // timing: figures in ns, cycle counts derived at the core clock
    // ************************************************************
    localparam int CLK_PERIOD_NS      = 5;
    localparam int WAIT_LOW_MAX_NS    = 10;
    localparam int WAIT_HIGHZ_MAX_NS  = 12;
    localparam int DATA_HIGHZ_MAX_NS  = 12;
    // longest times round down, never below one cycle
    localparam int WAIT_LOW_MAX_CYC   =
        (WAIT_LOW_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        WAIT_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int WAIT_HIGHZ_MAX_CYC =
        (WAIT_HIGHZ_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        WAIT_HIGHZ_MAX_NS / CLK_PERIOD_NS;
    localparam int DATA_HIGHZ_MAX_CYC =
        (DATA_HIGHZ_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        DATA_HIGHZ_MAX_NS / CLK_PERIOD_NS;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic CTL_RST_LEVEL  = 1'b1;
    localparam logic WAIT_RST_LEVEL = 1'b1;

    // ************************************************************
    // burst sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_LATENCY = 4'h2,
        ST_DATA    = 4'h4,
        ST_DONE    = 4'h8
    } burst_state_t;

endpackage

/* File: common/word_store_if.sv */
// port between the burst sequencer and its word store
`timescale 1ns/100ps
`default_nettype none
interface word_store_if #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
);
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W/8-1:0] byte_we;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;

    modport user  (output addr, output byte_we, output wdata,
                   input rdata);
    modport store (input addr, input byte_we, input wdata,
                   output rdata);
endinterface
`default_nettype wire

/* File: logic/burst_word_store.sv */
// word array with per-byte write strobes and registered read
`timescale 1ns/100ps
`default_nettype none
module burst_word_store
    import psram_port_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    input  wire logic clk_i,
    word_store_if.store port
);
    localparam int DEPTH = 1 << ADDR_W;

    // ************************************************************
    // byte lanes
    // ************************************************************
    // each lane owns its array so no two processes share one variable;
    // a lane with its strobe low keeps its old contents
    for (genvar b = 0; b < BYTES; b++) begin : g_lane
        logic [BYTE_W-1:0] lane_mem [0:DEPTH-1];

        // read runs every cycle so the next beat's word is always ready
        always_ff @(posedge clk_i) begin
            if (port.byte_we[b]) begin
                lane_mem[port.addr] <= port.wdata[b*BYTE_W +: BYTE_W];
            end
            port.rdata[b*BYTE_W +: BYTE_W] <= lane_mem[port.addr];
        end
    end
endmodule
`default_nettype wire

/* File: logic/sync_burst_psram_port.sv */
// synchronous burst read/write port of a 16-bit pseudo-static memory
//
// Notes on behaviour
// - wait goes low on select/strobe fall.
// - wait goes high at latency minus one.
// - wait floats when chip select rises.
// - burst starts at first clock of strobe.
// - read data floats after last clock.
// - data floats when select deasserted.
// - data floats when output enable deasserted.
// - data floats when byte enables deasserted.
// - write enable sampled at command edge.
// - byte masks sampled each write edge.
// - both bytes masked, word unwritten.
`timescale 1ns/100ps
`default_nettype none
module sync_burst_psram_port
    import psram_port_pkg::*;
#(
    parameter int ADDR_W    = ADDR_W_DEF,
    parameter int LATENCY   = LATENCY_DEF,
    parameter int BURST_LEN = BURST_LEN_DEF
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              burst_clk_i,
    input  wire logic              chip_sel_n_i,
    input  wire logic              addr_valid_strobe_n_i,
    input  wire logic              out_en_n_i,
    input  wire logic              write_en_n_i,
    input  wire logic              upper_byte_en_n_i,
    input  wire logic              lower_byte_en_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o,
    output logic      [BYTES-1:0]  data_oe_o,
    output logic                   wait_o,
    output logic                   wait_oe_o
);
    localparam int IDX_W = (BURST_LEN > 2) ? $clog2(BURST_LEN) : 1;
    localparam int CNT_W = $clog2(LATENCY + BURST_LEN + 1);
    localparam logic [CNT_W-1:0] WAIT_HIGH_AT = CNT_W'(LATENCY - 1);
    localparam logic [CNT_W-1:0] LAST_BEAT    = CNT_W'(BURST_LEN - 1);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [CTL_W-1:0]  ctl_s1_reg;
    logic [CTL_W-1:0]  ctl_s2_reg;
    logic [ADDR_W-1:0] addr_s1_reg;
    logic [ADDR_W-1:0] addr_s2_reg;
    logic [DATA_W-1:0] din_s1_reg;
    logic [DATA_W-1:0] din_s2_reg;
    logic              clk_prev_reg;
    logic              cs_prev_reg;
    logic              strobe_prev_reg;

    // every pin crosses two flops; edge detectors read only stage two
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctl_s1_reg <= {CTL_W{CTL_RST_LEVEL}};
            ctl_s2_reg <= {CTL_W{CTL_RST_LEVEL}};
        end else begin
            ctl_s1_reg <= {upper_byte_en_n_i, lower_byte_en_n_i,
                           write_en_n_i, out_en_n_i,
                           addr_valid_strobe_n_i, chip_sel_n_i,
                           burst_clk_i};
            ctl_s2_reg <= ctl_s1_reg;
        end
    end

    // address and data need no reset; they are only read when qualified
    always_ff @(posedge clk_i) begin
        addr_s1_reg <= addr_i;
        addr_s2_reg <= addr_s1_reg;
        din_s1_reg  <= data_i;
        din_s2_reg  <= din_s1_reg;
    end

    // previous levels for edge detection
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            clk_prev_reg    <= CTL_RST_LEVEL;
            cs_prev_reg     <= CTL_RST_LEVEL;
            strobe_prev_reg <= CTL_RST_LEVEL;
        end else begin
            clk_prev_reg    <= ctl_s2_reg[CTL_CLK];
            cs_prev_reg     <= ctl_s2_reg[CTL_CS];
            strobe_prev_reg <= ctl_s2_reg[CTL_STROBE];
        end
    end

    logic             clk_rise;
    logic             cs_n;
    logic             strobe_n;
    logic             cs_fall;
    logic             strobe_fall;
    logic [BYTES-1:0] byte_n;

    assign clk_rise    = ctl_s2_reg[CTL_CLK] && !clk_prev_reg;
    assign cs_n        = ctl_s2_reg[CTL_CS];
    assign strobe_n    = ctl_s2_reg[CTL_STROBE];
    assign cs_fall     = !cs_n && cs_prev_reg;
    assign strobe_fall = !strobe_n && strobe_prev_reg;
    assign byte_n      = {ctl_s2_reg[CTL_UPPER], ctl_s2_reg[CTL_LOWER]};

    // ************************************************************
    // burst start and sequencing
    // ************************************************************
    burst_state_t      state_reg;
    logic              armed_reg;
    logic              is_write_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              start;
    logic              beat;

    // only the first rising edge of one strobe-low period starts
    assign start = clk_rise && !cs_n && !strobe_n && armed_reg;
    assign beat  = clk_rise && (state_reg == ST_DATA) && !start;

    // re-armed by strobe high or deselect
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            armed_reg <= 1'b1;
        end else if (strobe_n || cs_n) begin
            armed_reg <= 1'b1;
        end else if (start) begin
            armed_reg <= 1'b0;
        end
    end

    // deselect stops any burst; a fresh strobe restarts from any state
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else if (cs_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else if (start) begin
            state_reg <= (LATENCY > 1) ? ST_LATENCY : ST_DATA;
            cnt_reg   <= '0;
        end else if (clk_rise) begin
            case (state_reg)
                ST_LATENCY: begin
                    if (cnt_reg + 1'b1 == WAIT_HIGH_AT) begin
                        state_reg <= ST_DATA;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_DATA: begin
                    if (cnt_reg == LAST_BEAT) begin
                        state_reg <= ST_DONE;
                    end
                    cnt_reg <= cnt_reg + 1'b1;
                end
                ST_IDLE, ST_DONE: begin
                    cnt_reg <= cnt_reg;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // direction is fixed by write enable at the command edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            is_write_reg <= 1'b0;
        end else if (start) begin
            is_write_reg <= !ctl_s2_reg[CTL_WE];
        end
    end

    // linear address, wrapping in the low bits of the burst length
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            addr_reg <= '0;
        end else if (start) begin
            addr_reg <= addr_s2_reg;
        end else if (beat) begin
            addr_reg[IDX_W-1:0] <= addr_reg[IDX_W-1:0] + 1'b1;
        end
    end

    // ************************************************************
    // word store and write path
    // ************************************************************
    word_store_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) store_port ();

    assign store_port.addr  = addr_reg;
    assign store_port.wdata = din_s2_reg;

    // a lane is written only when its byte enable is low at the beat
    for (genvar b = 0; b < BYTES; b++) begin : g_wr
        assign store_port.byte_we[b] =
            beat && is_write_reg && !byte_n[b];
    end

    burst_word_store #(.ADDR_W(ADDR_W)) u_store (
        .clk_i (clk_i),
        .port  (store_port)
    );

    // ************************************************************
    // read data and output enables
    // ************************************************************
    logic rd_live_reg;

    // a read word is held from its beat until the edge after the last
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rd_live_reg <= 1'b0;
        end else if (cs_n || start) begin
            rd_live_reg <= 1'b0;
        end else if (beat && !is_write_reg) begin
            rd_live_reg <= 1'b1;
        end else if (clk_rise && state_reg == ST_DONE) begin
            rd_live_reg <= 1'b0;
        end
    end

    // rdata was fetched at least one cycle before the beat
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            data_o <= '0;
        end else if (beat && !is_write_reg) begin
            data_o <= store_port.rdata;
        end
    end

    // enables follow the live levels, so any release floats at once
    for (genvar b = 0; b < BYTES; b++) begin : g_oe
        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                data_oe_o[b] <= 1'b0;
            end else begin
                data_oe_o[b] <= rd_live_reg
                    && !cs_n
                    && !ctl_s2_reg[CTL_OE]
                    && !byte_n[b];
            end
        end
    end

    // ************************************************************
    // wait signal
    // ************************************************************
    // driven only while selected; low until latency minus one
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wait_oe_o <= 1'b0;
            wait_o    <= WAIT_RST_LEVEL;
        end else if (cs_n) begin
            wait_oe_o <= 1'b0;
            wait_o    <= WAIT_RST_LEVEL;
        end else begin
            wait_oe_o <= 1'b1;
            if (start && LATENCY <= 1) begin
                wait_o <= 1'b1;
            end else if (cs_fall || strobe_fall || start) begin
                wait_o <= 1'b0;
            end else if (clk_rise && state_reg == ST_LATENCY
                         && cnt_reg + 1'b1 == WAIT_HIGH_AT) begin
                wait_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/burst_ctrl_model.sv */
// behavioural burst controller that drives the memory pins
`timescale 1ns/100ps
`default_nettype none
module burst_ctrl_model
    import psram_port_pkg::*;
#(
    parameter int ADDR_W    = 8,
    parameter int LATENCY   = 5,
    parameter int BURST_LEN = 4,
    parameter int HALF      = 4 // 40 ns burst clock period
) (
    input  wire logic              clk_i,
    output logic                   burst_clk_o,
    output logic                   chip_sel_n_o,
    output logic                   strobe_n_o,
    output logic                   out_en_n_o,
    output logic                   write_en_n_o,
    output logic                   upper_n_o,
    output logic                   lower_n_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] wdata_o,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic [BYTES-1:0]  data_oe_i,
    input  wire logic              wait_i,
    input  wire logic              wait_oe_i
);
    // ****************************************
    // beat buffers and captured observations
    // ****************************************
    logic [DATA_W-1:0] wd [BURST_LEN];
    logic [DATA_W-1:0] rd [BURST_LEN];
    logic [BYTES-1:0]  mask [BURST_LEN];
    logic [1:0]        ws_lo;
    logic [1:0]        ws_hi;
    logic [BYTES-1:0]  oe_after;
    // all control pins idle high, address and data at zero, burst clock stands still low
    initial begin
        burst_clk_o = 1'b0;
        {chip_sel_n_o, strobe_n_o, out_en_n_o} = 3'h7;
        {write_en_n_o, upper_n_o, lower_n_o} = 3'h7;
        addr_o = '0;
        wdata_o = 16'h0000;
    end
    // one burst; strobe stays low over edges 0 and 1; stop aborts it
    task automatic run(input logic wr_n, input logic [ADDR_W-1:0] a,
                       input logic hold, input int stop);
        int last;
        last = LATENCY + BURST_LEN;
        @(negedge clk_i);
        {chip_sel_n_o, strobe_n_o, out_en_n_o} <= 3'h0;
        {write_en_n_o, addr_o} <= {wr_n, a};
        {upper_n_o, lower_n_o} <= 2'b00;
        for (int e = 0; e <= last; e++) begin
            if (!wr_n && e >= LATENCY && e < last) begin
                wdata_o <= wd[e-LATENCY];
                {upper_n_o, lower_n_o} <= mask[e-LATENCY];
            end
            repeat (HALF) @(negedge clk_i);
            if (e == LATENCY - 1) ws_lo = {wait_oe_i, wait_i};
            if (e == LATENCY) ws_hi = {wait_oe_i, wait_i};
            if (e > LATENCY) begin
                // captured only when both byte drives are on
                rd[e-LATENCY-1] = (data_oe_i == 2'b11) ? data_i : 'x;
            end
            burst_clk_o <= 1'b1;
            repeat (HALF) @(negedge clk_i);
            burst_clk_o <= 1'b0;
            if (e == 1) strobe_n_o <= 1'b1;
            if (e == stop) break;
        end
        // taken before any pin lets go, so only the burst end clears it
        oe_after = data_oe_i;
        // a cut burst drops its pins one at a time: upper byte first,
        // then select on an even stop or output enable on an odd one
        if (stop < last) begin
            upper_n_o <= 1'b1;
            repeat (8) @(negedge clk_i);
            if (stop[0]) out_en_n_o <= 1'b1;
            if (!stop[0]) chip_sel_n_o <= 1'b1;
            repeat (8) @(negedge clk_i);
        end
        {out_en_n_o, upper_n_o, lower_n_o} <= 3'h7;
        wdata_o <= ~wdata_o; // released bus never shows the old word
        if (!hold || stop < last) chip_sel_n_o <= 1'b1;
        repeat (3) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: testbench/sync_burst_psram_port_assertions.sv */
// pin-level checks on the burst memory port
`timescale 1ns/100ps
`default_nettype none
module sync_burst_psram_port_assertions
    import psram_port_pkg::*;
#(
    parameter int BURST_LEN = 4
) (
    input wire logic             clk_i,
    input wire logic             reset_n_i,
    input wire logic             burst_clk_i,
    input wire logic             chip_sel_n_i,
    input wire logic             addr_valid_strobe_n_i,
    input wire logic             out_en_n_i,
    input wire logic             write_en_n_i,
    input wire logic             upper_byte_en_n_i,
    input wire logic             lower_byte_en_n_i,
    input wire logic [BYTES-1:0] data_oe_o,
    input wire logic             wait_o,
    input wire logic             wait_oe_o
);
    // ****************************************
    // burst clock rises seen while data drives
    // ****************************************
    logic       bclk_reg;
    logic [3:0] beat_reg;
    always_ff @(posedge clk_i) begin
        bclk_reg <= burst_clk_i;
    end
    // a drive window one beat too long shows up as an extra count
    always_ff @(posedge clk_i) begin
        if (data_oe_o == '0) begin
            beat_reg <= 4'h0;
        end else if (burst_clk_i && !bclk_reg) begin
            beat_reg <= beat_reg + 4'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_wait_low_start: assert property (
        $fell(addr_valid_strobe_n_i) && !chip_sel_n_i
        |-> ##[1:4] (wait_oe_o && !wait_o))
        else $error("wait not low after burst start");
    chk_wait_before_data: assert property (
        $rose(|data_oe_o) |-> wait_o && wait_oe_o)
        else $error("data driven before wait high");
    chk_wait_then_data: assert property (
        $rose(wait_o) && wait_oe_o && write_en_n_i && !out_en_n_i
        && !upper_byte_en_n_i && !lower_byte_en_n_i
        |-> ##[6:12] data_oe_o == 2'b11)
        else $error("no data one beat after wait high");
    chk_wait_float_desel: assert property (
        $rose(chip_sel_n_i) |-> ##[1:4] !wait_oe_o)
        else $error("wait still driven after deselect");
    chk_beat_count: assert property (
        beat_reg <= 4'(BURST_LEN))
        else $error("read data driven past burst end");
    chk_data_off_desel: assert property (
        $rose(chip_sel_n_i) |-> ##[1:4] data_oe_o == '0)
        else $error("data driven after deselect");
    chk_data_off_oe: assert property (
        $rose(out_en_n_i) |-> ##[1:4] data_oe_o == '0)
        else $error("data driven after output disable");
    chk_upper_off: assert property (
        $rose(upper_byte_en_n_i) |-> ##[1:4] !data_oe_o[1])
        else $error("upper byte driven after disable");
    chk_write_no_drive: assert property (
        !write_en_n_i && !$past(write_en_n_i, 4) |-> data_oe_o == '0)
        else $error("data driven during write burst");
endmodule

bind sync_burst_psram_port sync_burst_psram_port_assertions #(
    .BURST_LEN(BURST_LEN)
) u_sync_burst_psram_port_assertions (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .burst_clk_i(burst_clk_i),
    .chip_sel_n_i(chip_sel_n_i), .out_en_n_i(out_en_n_i),
    .addr_valid_strobe_n_i(addr_valid_strobe_n_i),
    .write_en_n_i(write_en_n_i), .upper_byte_en_n_i(upper_byte_en_n_i),
    .lower_byte_en_n_i(lower_byte_en_n_i), .data_oe_o(data_oe_o),
    .wait_o(wait_o), .wait_oe_o(wait_oe_o)
);
`default_nettype wire

/* File: testbench/sync_burst_psram_port_test.sv */
// self-checking bench for the burst memory port
`timescale 1ns/100ps
`default_nettype none
module sync_burst_psram_port_test import psram_port_pkg::*;;
    // ****************************************
    // clock, pins and reference memory
    // ****************************************
    localparam int AW = 8;
    localparam int BL = BURST_LEN_DEF;
    logic              clk_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic              bclk, cs_n, stb_n, oe_n, we_n, ub_n, lb_n;
    logic              wt, wt_oe;
    logic [AW-1:0]     addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [BYTES-1:0]  doe;
    logic [DATA_W-1:0] ref_mem [logic [AW-1:0]];
    int                n_fail = 0;
    int                samples_checked = 0;

    always #2.5 clk_i = ~clk_i;

    sync_burst_psram_port #(.ADDR_W(AW)) u_sync_burst_psram_port (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .burst_clk_i(bclk),
        .chip_sel_n_i(cs_n), .addr_valid_strobe_n_i(stb_n),
        .out_en_n_i(oe_n), .write_en_n_i(we_n),
        .upper_byte_en_n_i(ub_n), .lower_byte_en_n_i(lb_n),
        .addr_i(addr), .data_i(wdata), .data_o(rdata),
        .data_oe_o(doe), .wait_o(wt), .wait_oe_o(wt_oe));

    burst_ctrl_model #(.ADDR_W(AW)) u_burst_ctrl_model (
        .clk_i(clk_i), .burst_clk_o(bclk), .chip_sel_n_o(cs_n),
        .strobe_n_o(stb_n), .out_en_n_o(oe_n), .write_en_n_o(we_n),
        .upper_n_o(ub_n), .lower_n_o(lb_n), .addr_o(addr),
        .wdata_o(wdata), .data_i(rdata), .data_oe_i(doe),
        .wait_i(wt), .wait_oe_i(wt_oe));

    // compare and count
    task automatic check(input logic [DATA_W-1:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // word address of beat k, wrapping inside the burst group
    function automatic logic [AW-1:0] wrap(logic [AW-1:0] a, int k);
        return (a & ~AW'(BL - 1)) | ((a + AW'(k)) & AW'(BL - 1));
    endfunction
    // masked bytes keep the old content
    function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n,
                                                 logic [BYTES-1:0] m);
        return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
    endfunction
    // random beats; a masked burst always masks both bytes of beat 2
    task automatic wr_burst(input logic [AW-1:0] a, input logic masked);
        logic [BYTES-1:0] m;
        for (int k = 0; k < BL; k++) begin
            m = !masked ? 2'b00 : (k == 2) ? 2'b11 : BYTES'($urandom);
            u_burst_ctrl_model.wd[k] = DATA_W'($urandom);
            u_burst_ctrl_model.mask[k] = m;
            ref_mem[wrap(a, k)] = merge(ref_mem[wrap(a, k)],
                                        u_burst_ctrl_model.wd[k], m);
        end
        u_burst_ctrl_model.run(1'b0, a, 1'b1, 99);
    endtask
    // read burst, every beat and both wait phases compared
    task automatic rd_burst(input logic [AW-1:0] a, input logic hold);
        u_burst_ctrl_model.run(1'b1, a, hold, 99);
        for (int k = 0; k < BL; k++) begin
            check(u_burst_ctrl_model.rd[k], ref_mem[wrap(a, k)]);
        end
        check(DATA_W'(u_burst_ctrl_model.ws_lo), 16'h0002);
        check(DATA_W'(u_burst_ctrl_model.ws_hi), 16'h0003);
        check(DATA_W'(u_burst_ctrl_model.oe_after), 16'h0000);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // corner cases first, then random start addresses
    initial begin
        logic [AW-1:0] a;
        void'($urandom(32'h3091));
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        wr_burst(8'h03, 1'b0);
        wr_burst(8'h03, 1'b1);
        rd_burst(8'h03, 1'b0);
        u_burst_ctrl_model.run(1'b1, 8'h03, 1'b0, 2);
        u_burst_ctrl_model.run(1'b1, 8'h03, 1'b0, 6);
        u_burst_ctrl_model.run(1'b1, 8'h03, 1'b0, 7);
        rd_burst(8'h03, 1'b1);
        for (int t = 0; t < 8; t++) begin
            a = AW'($urandom);
            wr_burst(a, 1'b0);
            wr_burst(a, 1'b1);
            rd_burst(a, t[0]);
        end
        finish_test();
    end

    // hang guard, several times the expected run of about 2600 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
